//--- inc/rf_cfg_pkg.sv
// Constants for the RF front-end configuration register group
package rf_cfg_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // Register offsets
   localparam logic [7:0] OFF_N_OFF_COND = 8'h23;
   localparam logic [7:0] OFF_PULSE_WIDTH = 8'h24;
   localparam logic [7:0] OFF_TX_PHASE = 8'h25;
   localparam logic [7:0] OFF_RF_CFG = 8'h26;
   // Reset values
   localparam logic [7:0] RST_N_OFF_COND = 8'h88;
   localparam logic [7:0] RST_PULSE_WIDTH = 8'h26;
   localparam logic [7:0] RST_TX_PHASE = 8'h87;
   localparam logic [7:0] RST_RF_CFG = 8'h48;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   // Field positions
   localparam int UNMOD_MSB = 7;
   localparam int UNMOD_LSB = 4;
   localparam int MOD_MSB = 3;
   localparam int MOD_LSB = 0;
   localparam int DEMOD_CLK_BIT = 7;
   localparam int PHASE_MSB = 6;
   localparam int AMP_BIT = 7;
   localparam int GAIN_MSB = 6;
   localparam int GAIN_LSB = 4;
   localparam int SENS_MSB = 3;
   localparam int SENS_LSB = 0;
   // Soft power-down forces the top conductance bit
   localparam logic [3:0] COND_FORCE = 4'h8;
   // Receiver gain in dB
   localparam logic [5:0] GAIN_18DB = 6'h12;
   localparam logic [5:0] GAIN_23DB = 6'h17;
   localparam logic [5:0] GAIN_33DB = 6'h21;
   localparam logic [5:0] GAIN_38DB = 6'h26;
   localparam logic [5:0] GAIN_43DB = 6'h2B;
   localparam logic [5:0] GAIN_48DB = 6'h30;
   // Subcarrier period in carrier periods
   localparam logic [4:0] SUB_PERIOD = 5'h10;
   localparam logic [3:0] SUB_LOW_BASE = 4'h1;
   localparam logic [7:0] MILLER_EXTRA = 8'h01;
endpackage : rf_cfg_pkg

//--- inc/carrier_timer_if.sv
// Signals between the register group and its carrier-period timer
`timescale 1ns/1ps
`default_nettype none
interface carrier_timer_if;
   logic tick;
   logic initiator;
   logic target106;
   logic miller_start;
   logic sub_en;
   logic tx_start;
   logic [7:0] width;
   logic [6:0] phase;
   logic miller_pulse;
   logic subcarrier;
   logic tx_go;
   modport ctrl (output tick, initiator, target106, miller_start, sub_en, tx_start, width,
      phase, input miller_pulse, subcarrier, tx_go);
   modport timer (input tick, initiator, target106, miller_start, sub_en, tx_start, width,
      phase, output miller_pulse, subcarrier, tx_go);
endinterface : carrier_timer_if
`default_nettype wire

//--- rtl/carrier_timer.sv
// Carrier-period timer: Miller pulse, subcarrier duty cycle, transmit phase wait
`timescale 1ns/1ps
`default_nettype none
module carrier_timer import rf_cfg_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Control side
   carrier_timer_if.timer tif
);
   typedef enum logic {TX_IDLE, TX_WAIT} tx_state_t;

   logic mil_on_q, mil_on_d;
   logic [7:0] mil_cnt_q, mil_cnt_d;
   logic sub_q, sub_d;
   logic [3:0] sub_cnt_q, sub_cnt_d;
   logic [3:0] low_len, high_len, cur_len;
   tx_state_t tx_state_q, tx_state_d;
   logic [6:0] tx_cnt_q, tx_cnt_d;
   logic go_q, go_d;

   // Next values of all three timers
   always_comb begin
      mil_on_d = mil_on_q;
      mil_cnt_d = mil_cnt_q;
      // Pulse lasts width + 1 carrier periods; a new start retriggers
      if (tif.miller_start && tif.initiator) begin
         mil_on_d = 1'b1;
         mil_cnt_d = tif.width;
      end else if (mil_on_q && tif.tick) begin
         if (mil_cnt_q == 8'h00) begin
            mil_on_d = 1'b0;
         end else begin
            mil_cnt_d = mil_cnt_q - MILLER_EXTRA;
         end
      end
      // Low for (width mod 8) + 1 periods, high for the rest of 16
      low_len = {1'b0, tif.width[2:0]} + SUB_LOW_BASE;
      high_len = 4'(SUB_PERIOD - {1'b0, low_len});
      cur_len = sub_q ? high_len : low_len;
      sub_d = sub_q;
      sub_cnt_d = sub_cnt_q;
      if (!(tif.sub_en && tif.target106)) begin
         sub_d = 1'b0;
         sub_cnt_d = 4'h0;
      end else if (tif.tick) begin
         if (sub_cnt_q >= cur_len - 4'h1) begin
            sub_d = !sub_q;
            sub_cnt_d = 4'h0;
         end else begin
            sub_cnt_d = sub_cnt_q + 4'h1;
         end
      end
      // Extra wait of phase carrier periods ahead of transmission
      tx_state_d = tx_state_q;
      tx_cnt_d = tx_cnt_q;
      go_d = 1'b0;
      unique case (tx_state_q)
         TX_IDLE: begin
            if (tif.tx_start) begin
               if (tif.phase == 7'h00) begin
                  go_d = 1'b1;
               end else begin
                  tx_state_d = TX_WAIT;
                  tx_cnt_d = tif.phase;
               end
            end
         end
         TX_WAIT: begin
            if (tif.tick) begin
               if (tx_cnt_q == 7'h01) begin
                  go_d = 1'b1;
                  tx_state_d = TX_IDLE;
               end
               tx_cnt_d = tx_cnt_q - 7'h01;
            end
         end
      endcase
   end

   // Timer state registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mil_on_q <= 1'b0;
         mil_cnt_q <= 8'h00;
         sub_q <= 1'b0;
         sub_cnt_q <= 4'h0;
         tx_state_q <= TX_IDLE;
         tx_cnt_q <= 7'h00;
         go_q <= 1'b0;
      end else begin
         mil_on_q <= mil_on_d;
         mil_cnt_q <= mil_cnt_d;
         sub_q <= sub_d;
         sub_cnt_q <= sub_cnt_d;
         tx_state_q <= tx_state_d;
         tx_cnt_q <= tx_cnt_d;
         go_q <= go_d;
      end
   end

   assign tif.miller_pulse = mil_on_q;
   assign tif.subcarrier = sub_q;
   assign tif.tx_go = go_q;

   // Helper counters that only the checks read
   logic [8:0] mil_ticks_q;
   logic [8:0] mil_w_q;
   logic [3:0] low_ticks_q;
   logic [6:0] tx_ticks_q;
   logic [6:0] tx_ph_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mil_ticks_q <= 9'h000;
         mil_w_q <= 9'h000;
         low_ticks_q <= 4'h0;
         tx_ticks_q <= 7'h00;
         tx_ph_q <= 7'h00;
      end else begin
         if (tif.miller_start && tif.initiator) begin
            mil_ticks_q <= 9'h000;
            mil_w_q <= {1'b0, tif.width} + 9'h001;
         end else if (mil_on_q && tif.tick) begin
            mil_ticks_q <= mil_ticks_q + 9'h001;
         end
         if (sub_q || !(tif.sub_en && tif.target106)) begin
            low_ticks_q <= 4'h0;
         end else if (tif.tick) begin
            low_ticks_q <= low_ticks_q + 4'h1;
         end
         if (tx_state_q == TX_IDLE && tif.tx_start) begin
            tx_ticks_q <= 7'h00;
            tx_ph_q <= tif.phase;
         end else if (tx_state_q == TX_WAIT && tif.tick) begin
            tx_ticks_q <= tx_ticks_q + 7'h01;
         end
      end
   end

   sequence tx_last_tick_s;
      tx_state_q == TX_WAIT && tif.tick && tx_cnt_q == 7'h01;
   endsequence

   miller_width_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(mil_on_q) |-> mil_ticks_q == mil_w_q)
      else $error("Miller pulse length differs from width plus one");
   sub_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($rose(sub_q) && $stable(tif.width)) |-> low_ticks_q == low_len)
      else $error("Subcarrier low phase has wrong length");
   phase_go_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      tx_last_tick_s |=> go_q ##1 !go_q)
      else $error("Transmit start not one pulse after phase wait");
   phase_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      go_q |-> tx_ticks_q == tx_ph_q)
      else $error("Transmit wait differs from programmed phase");
endmodule : carrier_timer
`default_nettype wire

//--- rtl/rf_frontend_config_regs.sv
// RF front-end configuration registers with driver code selection and timing
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Off unmodulated code used when driver off or load-modulating
// - Off modulated code used when driver off or load-modulating
// - Soft power-down forces code MSB high
// - Load modulation uses the off-state codes
// - Miller pulse lasts width plus one periods
// - Subcarrier low (width mod 8)+1, high rest
// - Phase value adds carrier cycles before transmit
// - Phase bit 7 selects field-derived demodulator clock
// - Gain code decodes to documented dB table
// - Config bit 7 enables level detector amplifier
// - Low nibble sets level detector sensitivity
module rf_frontend_config_regs import rf_cfg_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Driver state and on-state codes
   input wire logic driver_on,
   input wire logic soft_power_down,
   input wire logic load_modulate,
   input wire logic [3:0] unmod_n_on_conductance,
   input wire logic [3:0] mod_n_on_conductance,
   // Role and timing requests
   input wire logic carrier_tick,
   input wire logic initiator_mode,
   input wire logic target_106_mode,
   input wire logic miller_start,
   input wire logic subcarrier_enable,
   input wire logic tx_start,
   // Driver codes
   output logic [3:0] n_unmod_code,
   output logic [3:0] n_mod_code,
   // Receiver settings
   output logic demod_clock_from_field,
   output logic [5:0] receiver_gain_db,
   output logic field_detector_amp_on,
   output logic [3:0] field_detector_sensitivity,
   // Timing outputs
   output logic miller_pulse,
   output logic subcarrier_out,
   output logic tx_go
);
   logic [7:0] n_off_q, n_off_d;
   logic [7:0] width_q, width_d;
   logic [7:0] phase_q, phase_d;
   logic [7:0] rf_cfg_q, rf_cfg_d;
   logic [7:0] rdata_q, rdata_d;
   logic [3:0] unmod_q, unmod_d;
   logic [3:0] mod_q, mod_d;
   logic demod_q, demod_d;
   logic [5:0] gain_q, gain_d;
   logic amp_q, amp_d;
   logic [3:0] sens_q, sens_d;
   logic use_off;
   logic [3:0] unmod_n_off_conductance;
   logic [3:0] mod_n_off_conductance;
   logic [2:0] receiver_gain_select;

   carrier_timer_if tif ();

   // Register writes and read data; reads never disturb stored values
   always_comb begin
      n_off_d = n_off_q;
      width_d = width_q;
      phase_d = phase_q;
      rf_cfg_d = rf_cfg_q;
      rdata_d = RD_UNMAPPED;
      if (reg_wr) begin
         unique case (reg_addr)
            OFF_N_OFF_COND: n_off_d = reg_wdata;
            OFF_PULSE_WIDTH: width_d = reg_wdata;
            OFF_TX_PHASE: phase_d = reg_wdata;
            OFF_RF_CFG: rf_cfg_d = reg_wdata;
            default: ;
         endcase
      end
      // Read-back shows stored bits, never the forced driver code
      if (reg_rd) begin
         unique case (reg_addr)
            OFF_N_OFF_COND: rdata_d = n_off_q;
            OFF_PULSE_WIDTH: rdata_d = width_q;
            OFF_TX_PHASE: rdata_d = phase_q;
            OFF_RF_CFG: rdata_d = rf_cfg_q;
            default: rdata_d = RD_UNMAPPED;
         endcase
      end
   end

   // Register storage
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         n_off_q <= RST_N_OFF_COND;
         width_q <= RST_PULSE_WIDTH;
         phase_q <= RST_TX_PHASE;
         rf_cfg_q <= RST_RF_CFG;
         rdata_q <= RD_UNMAPPED;
      end else begin
         n_off_q <= n_off_d;
         width_q <= width_d;
         phase_q <= phase_d;
         rf_cfg_q <= rf_cfg_d;
         rdata_q <= rdata_d;
      end
   end

   assign unmod_n_off_conductance = n_off_q[UNMOD_MSB:UNMOD_LSB];
   assign mod_n_off_conductance = n_off_q[MOD_MSB:MOD_LSB];
   assign receiver_gain_select = rf_cfg_q[GAIN_MSB:GAIN_LSB];

   // Off codes when the driver is off or the block load-modulates
   assign use_off = !driver_on || load_modulate;

   // Driver codes and receiver settings, registered so outputs are glitch free
   always_comb begin
      unmod_d = use_off ? unmod_n_off_conductance : unmod_n_on_conductance;
      mod_d = use_off ? mod_n_off_conductance : mod_n_on_conductance;
      // Forcing acts on the delivered code only
      if (soft_power_down) begin
         unmod_d = unmod_d | COND_FORCE;
         mod_d = mod_d | COND_FORCE;
      end
      demod_d = phase_q[DEMOD_CLK_BIT];
      amp_d = rf_cfg_q[AMP_BIT];
      sens_d = rf_cfg_q[SENS_MSB:SENS_LSB];
      // Low codes repeat the lowest two gains
      unique case (receiver_gain_select)
         3'h0, 3'h2: gain_d = GAIN_18DB;
         3'h1, 3'h3: gain_d = GAIN_23DB;
         3'h4: gain_d = GAIN_33DB;
         3'h5: gain_d = GAIN_38DB;
         3'h6: gain_d = GAIN_43DB;
         3'h7: gain_d = GAIN_48DB;
      endcase
   end

   // Output registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         unmod_q <= 4'h0;
         mod_q <= 4'h0;
         demod_q <= 1'b0;
         gain_q <= 6'h00;
         amp_q <= 1'b0;
         sens_q <= 4'h0;
      end else begin
         unmod_q <= unmod_d;
         mod_q <= mod_d;
         demod_q <= demod_d;
         gain_q <= gain_d;
         amp_q <= amp_d;
         sens_q <= sens_d;
      end
   end

   // Timer control; width is trusted to fit half a bit period
   assign tif.tick = carrier_tick;
   assign tif.initiator = initiator_mode;
   assign tif.target106 = target_106_mode;
   assign tif.miller_start = miller_start;
   assign tif.sub_en = subcarrier_enable;
   assign tif.tx_start = tx_start;
   assign tif.width = width_q;
   assign tif.phase = phase_q[PHASE_MSB:0];

   carrier_timer u_timer (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tif(tif.timer)
   );

   // Outputs straight from flip-flops
   assign reg_rdata = rdata_q;
   assign n_unmod_code = unmod_q;
   assign n_mod_code = mod_q;
   assign demod_clock_from_field = demod_q;
   assign receiver_gain_db = gain_q;
   assign field_detector_amp_on = amp_q;
   assign field_detector_sensitivity = sens_q;
   assign miller_pulse = tif.miller_pulse;
   assign subcarrier_out = tif.subcarrier;
   assign tx_go = tif.tx_go;

   sequence off_write_then_read_s;
      reg_wr && reg_addr == OFF_N_OFF_COND ##1 reg_rd && reg_addr == OFF_N_OFF_COND;
   endsequence

   unmod_on_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (driver_on && !load_modulate && !soft_power_down)
      |=> n_unmod_code == $past(unmod_n_on_conductance))
      else $error("Unmodulated code not taken from on-state value");
   mod_off_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!driver_on && !soft_power_down && !$past(reg_wr))
      |=> n_mod_code == $past(mod_n_off_conductance))
      else $error("Modulated code not taken from off-state register");
   pd_force_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      soft_power_down |=> n_unmod_code[3] && n_mod_code[3])
      else $error("Power-down did not force code MSB");
   load_mod_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (load_modulate && driver_on && !soft_power_down)
      |=> n_unmod_code == $past(unmod_n_off_conductance))
      else $error("Load modulation did not use off-state code");
   readback_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      off_write_then_read_s |=> reg_rdata == $past(reg_wdata, 2))
      else $error("Read-back differs from written value");
   demod_clk_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFF_TX_PHASE) |=> ##1 demod_clock_from_field == $past(reg_wdata[7], 2))
      else $error("Demodulator clock select not following bit 7");
   gain_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (receiver_gain_select[2] == 1'b0)
      |=> receiver_gain_db == ($past(receiver_gain_select[0]) ? GAIN_23DB : GAIN_18DB))
      else $error("Low receiver gain code decoded wrong");
   amp_sens_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFF_RF_CFG)
      |=> ##1 (field_detector_amp_on == $past(reg_wdata[7], 2)
      && field_detector_sensitivity == $past(reg_wdata[3:0], 2)))
      else $error("Level detector settings not following register");
endmodule : rf_frontend_config_regs
`default_nettype wire

//--- bench/rf_frontend_config_regs_test.sv
// Self-checking testbench for the RF front-end configuration register group
`timescale 1ns/1ps
`default_nettype none
module rf_frontend_config_regs_test;
   import rf_cfg_pkg::*;
   // Stimulus and observed signals
   logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic driver_on = 1'b0, soft_power_down = 1'b0, load_modulate = 1'b0;
   logic [3:0] unmod_on = 4'h3, mod_on = 4'h6, n_unmod_code, n_mod_code, sens;
   logic carrier_tick = 1'b0, initiator_mode = 1'b0, target_106_mode = 1'b0;
   logic miller_start = 1'b0, subcarrier_enable = 1'b0, tx_start = 1'b0, tick_en = 1'b1;
   logic demod, amp, miller_pulse, subcarrier_out, tx_go;
   logic [5:0] gain_db;
   logic [1:0] tdiv = 2'h0;
   int mismatches = 0, n_tests = 0, n;
   logic [5:0] gain_tab [8] = '{GAIN_18DB, GAIN_23DB, GAIN_18DB, GAIN_23DB,
      GAIN_33DB, GAIN_38DB, GAIN_43DB, GAIN_48DB};
   logic [7:0] w_tab [2] = '{8'h0A, 8'hF8};

   rf_frontend_config_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .driver_on(driver_on), .soft_power_down(soft_power_down),
      .load_modulate(load_modulate), .unmod_n_on_conductance(unmod_on),
      .mod_n_on_conductance(mod_on), .carrier_tick(carrier_tick),
      .initiator_mode(initiator_mode), .target_106_mode(target_106_mode),
      .miller_start(miller_start), .subcarrier_enable(subcarrier_enable),
      .tx_start(tx_start), .n_unmod_code(n_unmod_code), .n_mod_code(n_mod_code),
      .demod_clock_from_field(demod), .receiver_gain_db(gain_db),
      .field_detector_amp_on(amp), .field_detector_sensitivity(sens),
      .miller_pulse(miller_pulse), .subcarrier_out(subcarrier_out), .tx_go(tx_go));

   // 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   // Carrier tick every fourth cycle, so pulse edges never sit next to a tick
   always @(posedge ref_clk) begin
      tdiv <= tdiv + 2'h1;
      carrier_tick <= tick_en && (tdiv == 2'h3);
   end

   // Compare seen against expected, case equality so unknowns fail
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s: got %h, expected %h", $time, what, seen, exp);
      end
   endtask : chk

   // Verdict and end of run
   task automatic results();
      $display("Checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   task automatic timeout(input string what);
      mismatches++;
      $display("[ERR] %0t timeout waiting for %s", $time, what);
      results();
   endtask : timeout

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // One-cycle read strobe; data is looked at in the following cycle only
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk(reg_rdata, exp, "read data");
   endtask : rd

   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask : cyc

   // Count ticks seen at edges while a timing output holds a level
   task automatic ticks_while(input bit sub, input logic lvl, output int cnt);
      int k;
      bit seen;
      cnt = 0;
      k = 0;
      seen = 1'b0;
      while (k < 400) begin
         @(posedge ref_clk);
         k++;
         if ((sub ? subcarrier_out : miller_pulse) === lvl) begin
            seen = 1'b1;
            if (carrier_tick === 1'b1) cnt++;
         end else if (seen) break;
      end
      if (k >= 400) timeout("timing level");
   endtask : ticks_while

   // Set driver state, then check both delivered codes
   task automatic drv(input logic on, input logic lm, input logic pd,
      input logic [3:0] eu, input logic [3:0] em);
      @(posedge ref_clk);
      driver_on <= on;
      load_modulate <= lm;
      soft_power_down <= pd;
      cyc(2);
      @(negedge ref_clk);
      chk({4'h0, n_unmod_code}, {4'h0, eu}, "unmod code");
      chk({4'h0, n_mod_code}, {4'h0, em}, "mod code");
   endtask : drv

   initial begin
      int k;
      logic hi;
      // Reset for five cycles
      cyc(5);
      chk({2'h0, gain_db}, 8'h00, "gain in reset");
      rst_n <= 1'b1;
      cyc(3);
      // Reset values, unmapped reads and derived settings
      rd(OFF_N_OFF_COND, 8'h88);
      rd(OFF_PULSE_WIDTH, 8'h26);
      rd(OFF_TX_PHASE, 8'h87);
      rd(OFF_RF_CFG, 8'h48);
      rd(8'h22, 8'h00);
      rd(8'h27, 8'h00);
      chk({7'h0, demod}, 8'h01, "demod clock");
      chk({2'h0, gain_db}, {2'h0, GAIN_33DB}, "gain");
      chk({4'h0, sens}, 8'h08, "sensitivity");
      $display("test reset done");
      // Unmapped write reads back as zero; write, then read after one idle cycle
      wr(8'h27, 8'hFF);
      wr(8'h22, 8'hFF);
      wr(OFF_N_OFF_COND, 8'h52);
      rd(OFF_N_OFF_COND, 8'h52);
      rd(8'h27, 8'h00);
      // Driver code selection and soft power-down forcing
      drv(1'b0, 1'b0, 1'b0, 4'h5, 4'h2);
      drv(1'b1, 1'b0, 1'b0, 4'h3, 4'h6);
      drv(1'b1, 1'b1, 1'b0, 4'h5, 4'h2);
      drv(1'b0, 1'b0, 1'b1, 4'hD, 4'hA);
      drv(1'b1, 1'b0, 1'b1, 4'hB, 4'hE);
      rd(OFF_N_OFF_COND, 8'h52);
      drv(1'b0, 1'b0, 1'b0, 4'h5, 4'h2);
      $display("test driver codes done");
      // Every gain code, with amplifier and sensitivity fields
      for (int c = 0; c < 8; c++) begin
         wr(OFF_RF_CFG, {c[0], c[2:0], c[3:0] ^ 4'h9});
         cyc(3);
         chk({2'h0, gain_db}, {2'h0, gain_tab[c]}, "gain");
         chk({7'h0, amp}, {7'h0, c[0]}, "amp");
         chk({4'h0, sens}, {4'h0, c[3:0] ^ 4'h9}, "sensitivity");
         rd(OFF_RF_CFG, {c[0], c[2:0], c[3:0] ^ 4'h9});
      end
      $display("test receiver done");
      // Miller pulse length for two widths, then a start without initiator role
      initiator_mode <= 1'b1;
      for (int w = 0; w < 6; w += 5) begin
         // Small widths stay well inside half a bit period
         wr(OFF_PULSE_WIDTH, w[7:0]);
         @(posedge ref_clk);
         miller_start <= 1'b1;
         @(posedge ref_clk);
         miller_start <= 1'b0;
         ticks_while(1'b0, 1'b1, n);
         chk(n[7:0], w[7:0] + 8'h01, "miller ticks");
      end
      initiator_mode <= 1'b0;
      @(posedge ref_clk);
      miller_start <= 1'b1;
      @(posedge ref_clk);
      miller_start <= 1'b0;
      hi = 1'b0;
      repeat (8) begin
         @(posedge ref_clk);
         if (miller_pulse !== 1'b0) hi = 1'b1;
      end
      chk({7'h0, hi}, 8'h00, "miller refused");
      $display("test miller done");
      // Subcarrier duty cycle, idle while the target role is off
      subcarrier_enable <= 1'b1;
      cyc(20);
      chk({7'h0, subcarrier_out}, 8'h00, "subcarrier idle");
      for (int i = 0; i < 2; i++) begin
         target_106_mode <= 1'b0;
         wr(OFF_PULSE_WIDTH, w_tab[i]);
         target_106_mode <= 1'b1;
         ticks_while(1'b1, 1'b1, n);
         chk(n[7:0], 8'h0F - {5'h0, w_tab[i][2:0]}, "subcarrier high");
         ticks_while(1'b1, 1'b0, n);
         chk(n[7:0], {5'h0, w_tab[i][2:0]} + 8'h01, "subcarrier low");
      end
      target_106_mode <= 1'b0;
      subcarrier_enable <= 1'b0;
      $display("test subcarrier done");
      // Transmit phase wait for a zero and a non-zero value
      for (int p = 0; p < 6; p += 5) begin
         wr(OFF_TX_PHASE, p[7:0]);
         cyc(3);
         chk({7'h0, demod}, 8'h00, "demod clock");
         @(posedge ref_clk);
         tx_start <= 1'b1;
         @(posedge ref_clk);
         tx_start <= 1'b0;
         n = 0;
         k = 0;
         while (k < 200) begin
            @(posedge ref_clk);
            k++;
            if (tx_go === 1'b1) break;
            // The first edge after the one that takes the start counts no tick of the wait
            if (k > 1 && carrier_tick === 1'b1) n++;
         end
         if (k >= 200) timeout("transmit go");
         chk(n[7:0], p[7:0], "phase ticks");
         @(posedge ref_clk);
         chk({7'h0, tx_go}, 8'h00, "go width");
      end
      $display("test phase done");
      results();
   end
endmodule : rf_frontend_config_regs_test
`default_nettype wire
